// >>> shared/atf_map.svh
`ifndef ATF_MAP_SVH
`define ATF_MAP_SVH

// Register offsets on the task-file I/O bus
`define ATF_OFS_DRIVE_HEAD 4'h6
`define ATF_OFS_STATUS_CMD 4'h7
`define ATF_OFS_CTRL_ALT 4'hE
`define ATF_OFS_DRIVE_ADDR 4'hF

// Field positions
`define ATF_DC_SRST_BIT 2
`define ATF_DC_IDIS_BIT 1
`define ATF_ST_BUSY_BIT 7
`define ATF_ST_DRQ_BIT 3
`define ATF_DH_DRV_BIT 4
`define ATF_DA_WTG_BIT 6
`define ATF_DA_DS1_BIT 1
`define ATF_DA_DS0_BIT 0

// Reset values
`define ATF_DH_RESET 8'hA0
`define ATF_DH_FIXED_ONES 8'hA0

// Class 2 and class 3 command codes
`define ATF_CMD_FORMAT_TRACK 8'h50
`define ATF_CMD_WRITE_BUFFER 8'hE8
`define ATF_CMD_WRITE_LONG0 8'h32
`define ATF_CMD_WRITE_LONG1 8'h33
`define ATF_CMD_WRITE_SEC0 8'h30
`define ATF_CMD_WRITE_SEC1 8'h31
`define ATF_CMD_WRITE_NOERASE 8'h38
`define ATF_CMD_WRITE_VERIFY 8'h3C
`define ATF_CMD_WRITE_MULT 8'hC5
`define ATF_CMD_WRITE_MULT_NE 8'hCD

// Timing
`define ATF_CLK_PERIOD_NS 100
`define ATF_BUSY_SET_NS 400
`define ATF_DRQ_C2_US 700
`define ATF_DRQ_C3_MS 20
`define ATF_BUSY_SET_CYCLES (`ATF_BUSY_SET_NS / `ATF_CLK_PERIOD_NS)
`define ATF_DRQ_C2_CYCLES (`ATF_DRQ_C2_US * 1000 / `ATF_CLK_PERIOD_NS)
`define ATF_DRQ_C3_CYCLES (`ATF_DRQ_C3_MS * 1000000 / `ATF_CLK_PERIOD_NS)
`define ATF_TIMER_W 18

`endif

// >>> shared/atf_pkg.sv
package atf_pkg;

  typedef enum logic [1:0] {ATF_CLS1, ATF_CLS2, ATF_CLS3} atf_class_t;

  typedef enum logic [1:0] {ATF_IDLE, ATF_EXEC, ATF_PREP, ATF_XFER}
    atf_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } atf_host_req_t;

  typedef struct packed {
    logic soft_reset_request;
    logic interrupt_disable_n;
  } atf_dev_ctrl_t;

endpackage

// >>> hw/atf_drq_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "atf_map.svh"

module atf_drq_timer #(
  parameter int unsigned W = `ATF_TIMER_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic expired
);

  logic [W-1:0] count;

  // Pulse in the last allowed cycle of the wait
  assign expired = run && (count == limit - {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (!run || expired)
      count <= '0;
    else
      count <= count + {{(W-1){1'b0}}, 1'b1};
  end

endmodule // atf_drq_timer
`default_nettype wire

// >>> hw/atf_task_ctrl.sv
// Notes on behaviour
// - Soft reset bit set holds task-file logic in reset until written back 0
// - Soft reset leaves card configuration registers untouched
// - Interrupt disable 1 blocks all host interrupts; 0 allows them
// - Same disable bit gates the configuration status interrupt bit
// - Interrupt disable cleared at power-on and every reset
// - Device control write ignores bits 0 and 3 and upper four bits
// - Drive address bit 6 reads 0 while a write is in progress
// - Drive address bits 5..2 return inverted head bits 3..0
// - Bits 1 and 0 read 0 when drive 1 or 0 is active and selected
// - Class 1 command sets BUSY within 400 ns
// - Class 2: BUSY within 400 ns, DRQ within 700 us, then BUSY drops
// - Class 3: BUSY within 400 ns, DRQ within 20 ms, then BUSY drops
// - While BUSY the device owns command register; host locked out
// - DRQ set whenever data must move through the data register
// - Drive/head low nibble holds head bits or LBA 27..24
// - Alternate status read keeps pending interrupt; status read clears it
`timescale 1ns/10ps
`default_nettype none
`include "atf_map.svh"

module atf_task_ctrl #(
  parameter int unsigned DRQ_C2_CYCLES = `ATF_DRQ_C2_CYCLES,
  parameter int unsigned DRQ_C3_CYCLES = `ATF_DRQ_C3_CYCLES,
  parameter bit ANSWER_DRIVE_ADDR = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire atf_pkg::atf_host_req_t host_req,
  output logic [7:0] host_rdata,
  output logic [7:0] host_rdata_oe,
  output logic host_irq,
  output logic cfg_int_status,
  output logic soft_reset_active,
  output logic [7:0] cmd_code,
  output logic cmd_start,
  output atf_pkg::atf_class_t cmd_class,
  output logic [7:0] drive_head,
  output logic busy,
  output logic drq,
  input wire logic [7:0] status_misc,
  input wire logic write_in_progress,
  input wire logic card_is_drive1,
  input wire logic drive_active,
  input wire logic buffer_ready,
  input wire logic xfer_req,
  input wire logic transfer_done,
  input wire logic cmd_done,
  input wire logic irq_event
);

  localparam int unsigned TW = `ATF_TIMER_W;
  localparam int unsigned BUSY_SET_CYCLES = `ATF_BUSY_SET_CYCLES;

  function automatic atf_pkg::atf_class_t class_of(input logic [7:0] code);
    unique case (code)
      `ATF_CMD_WRITE_MULT, `ATF_CMD_WRITE_MULT_NE:
        class_of = atf_pkg::ATF_CLS3;
      `ATF_CMD_FORMAT_TRACK, `ATF_CMD_WRITE_BUFFER, `ATF_CMD_WRITE_LONG0,
      `ATF_CMD_WRITE_LONG1, `ATF_CMD_WRITE_SEC0, `ATF_CMD_WRITE_SEC1,
      `ATF_CMD_WRITE_NOERASE, `ATF_CMD_WRITE_VERIFY:
        class_of = atf_pkg::ATF_CLS2;
      default:
        class_of = atf_pkg::ATF_CLS1;
    endcase
  endfunction

  atf_pkg::atf_dev_ctrl_t ctrl;
  atf_pkg::atf_state_t state;
  atf_pkg::atf_state_t next_state;
  logic int_pending;
  logic timer_expired;

  wire wr_ctrl = host_req.wr && host_req.addr == `ATF_OFS_CTRL_ALT;
  wire wr_cmd = host_req.wr && host_req.addr == `ATF_OFS_STATUS_CMD;
  wire wr_dh = host_req.wr && host_req.addr == `ATF_OFS_DRIVE_HEAD;
  wire rd_status = host_req.rd && host_req.addr == `ATF_OFS_STATUS_CMD;
  wire rd_alt = host_req.rd && host_req.addr == `ATF_OFS_CTRL_ALT;
  wire rd_dh = host_req.rd && host_req.addr == `ATF_OFS_DRIVE_HEAD;
  wire rd_da = host_req.rd && host_req.addr == `ATF_OFS_DRIVE_ADDR;
  wire srst = ctrl.soft_reset_request;
  // Writes to command and drive/head are locked out while busy
  wire cmd_accept = wr_cmd && !busy;
  wire dh_accept = wr_dh && !busy;
  wire [TW-1:0] drq_limit = (cmd_class == atf_pkg::ATF_CLS3)
    ? TW'(DRQ_C3_CYCLES) : TW'(DRQ_C2_CYCLES);
  wire prep_done = buffer_ready || timer_expired;
  wire drive_sel = drive_active &&
    (drive_head[`ATF_DH_DRV_BIT] == card_is_drive1);
  wire [7:0] status_word = {busy, status_misc[6:4], drq, status_misc[2],
    1'b0, status_misc[0]};
  wire [7:0] drive_addr_word = {1'b0, !write_in_progress,
    ~drive_head[3:0],
    !(drive_sel && card_is_drive1),
    !(drive_sel && !card_is_drive1)};
  wire [7:0] next_rdata = rd_da ? drive_addr_word
    : rd_dh ? drive_head : status_word;
  wire [7:0] next_oe = rd_da ? (ANSWER_DRIVE_ADDR ? 8'h7F : 8'h00)
    : (rd_status || rd_alt || rd_dh) ? 8'hFF : 8'h00;
  wire int_set = irq_event || (state == atf_pkg::ATF_EXEC && cmd_done);

  // Busy while soft reset is held and while the device owns the registers
  assign busy = srst || state == atf_pkg::ATF_EXEC
    || state == atf_pkg::ATF_PREP;
  assign drq = state == atf_pkg::ATF_XFER;
  assign host_irq = int_pending && !ctrl.interrupt_disable_n;
  assign cfg_int_status = host_irq;
  assign soft_reset_active = srst;

  atf_drq_timer #(
    .W(TW)
  ) u_drq_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(state == atf_pkg::ATF_PREP),
    .limit(drq_limit),
    .expired(timer_expired)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      atf_pkg::ATF_IDLE:
        if (cmd_accept)
          next_state = (class_of(host_req.wdata) == atf_pkg::ATF_CLS1)
            ? atf_pkg::ATF_EXEC : atf_pkg::ATF_PREP;
      atf_pkg::ATF_EXEC:
        if (xfer_req)
          next_state = atf_pkg::ATF_XFER;
        else if (cmd_done)
          next_state = atf_pkg::ATF_IDLE;
      atf_pkg::ATF_PREP:
        if (prep_done)
          next_state = atf_pkg::ATF_XFER;
      atf_pkg::ATF_XFER:
        if (transfer_done)
          next_state = atf_pkg::ATF_EXEC;
    endcase
  end

  // Device control: only bits 2 and 1 are stored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= '0;
    else if (wr_ctrl)
    begin
      ctrl.soft_reset_request <= host_req.wdata[`ATF_DC_SRST_BIT];
      ctrl.interrupt_disable_n <= host_req.wdata[`ATF_DC_SRST_BIT] ? 1'b0
        : host_req.wdata[`ATF_DC_IDIS_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= atf_pkg::ATF_IDLE;
      drive_head <= `ATF_DH_RESET;
      cmd_code <= 8'h00;
      cmd_class <= atf_pkg::ATF_CLS1;
      cmd_start <= 1'b0;
    end
    else if (srst)
    begin
      state <= atf_pkg::ATF_IDLE;
      drive_head <= `ATF_DH_RESET;
      cmd_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd_start <= cmd_accept;
      if (dh_accept)
        drive_head <= host_req.wdata | `ATF_DH_FIXED_ONES;
      if (cmd_accept)
      begin
        cmd_code <= host_req.wdata;
        cmd_class <= class_of(host_req.wdata);
      end
    end
  end

  // Set wins over the clear from a status read
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      int_pending <= 1'b0;
    else if (srst)
      int_pending <= 1'b0;
    else if (int_set)
      int_pending <= 1'b1;
    else if (rd_status)
      int_pending <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_rdata <= 8'h00;
      host_rdata_oe <= 8'h00;
    end
    else
    begin
      host_rdata <= next_rdata;
      host_rdata_oe <= next_oe;
    end
  end

  sequence s_cmd_taken;
    !srst && cmd_accept;
  endsequence

  sequence s_busy_seen;
    ##[1:4] busy;
  endsequence

  a_srst_holds_busy: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (srst && !wr_ctrl) |=> busy && state == atf_pkg::ATF_IDLE)
    else $error("soft reset did not hold device busy");

  a_idis_blocks_irq: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctrl.interrupt_disable_n |-> !host_irq && !cfg_int_status)
    else $error("interrupt raised while disabled");

  a_idis_cleared_srst: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_ctrl && host_req.wdata[`ATF_DC_SRST_BIT]) |=>
      !ctrl.interrupt_disable_n)
    else $error("disable bit not cleared by soft reset");

  a_busy_on_cmd: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_cmd_taken |-> s_busy_seen)
    else $error("busy not set within 400 ns of command");

  a_drq_deadline: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state == atf_pkg::ATF_PREP && timer_expired && !srst && !wr_ctrl) |=>
      drq && !busy)
    else $error("drq deadline missed");

  a_busy_drops_drq: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(drq) |-> ##[0:BUSY_SET_CYCLES] !busy)
    else $error("busy stayed after drq");

  a_cmd_lockout: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (busy && wr_cmd) |=> !cmd_start && $stable(cmd_code))
    else $error("command taken while busy");

  a_da_readback: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rd_da |=> host_rdata[5:2] == ~$past(drive_head[3:0])
      && host_rdata[6] == !$past(write_in_progress))
    else $error("drive address readback wrong");

  a_alt_keeps_int: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rd_alt && int_pending && !srst) |=> int_pending)
    else $error("alternate status read cleared interrupt");

  a_status_clears: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rd_status && !int_set) |=> !int_pending)
    else $error("status read left interrupt pending");

endmodule // atf_task_ctrl
`default_nettype wire

// >>> testbench/atf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module atf_host_model (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic [7:0] host_rdata,
  output var atf_pkg::atf_host_req_t host_req
);
  initial host_req = '0;
  task automatic wr_raw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_req <= {1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    host_req <= '0;
    #1;
  endtask
  // Parameters go in first; a command waits up to 200 cycles for busy to clear
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (a == 4'h7 && busy !== 1'b0 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    wr_raw(a, d);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    host_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    host_req <= '0;
    #1;
    d = host_rdata;
  endtask
endmodule // atf_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys, rst_n, host_irq, cfg_int_status, soft_reset_active;
  logic cmd_start, busy, drq, write_in_progress, card_is_drive1;
  logic drive_active, buffer_ready, xfer_req, transfer_done, cmd_done;
  logic irq_event;
  logic [7:0] host_rdata, host_rdata_oe, cmd_code, drive_head, status_misc;
  logic [7:0] rd;
  atf_pkg::atf_host_req_t host_req;
  atf_pkg::atf_class_t cmd_class;
  int mismatches, comparisons, cycles;
  logic [7:0] codes [10] = '{8'h50, 8'hE8, 8'h32, 8'h33, 8'h30, 8'h31,
    8'h38, 8'h3C, 8'hC5, 8'hCD};

  atf_host_model h (.clk_sys, .busy, .host_rdata, .host_req);
  atf_task_ctrl #(.DRQ_C2_CYCLES(20), .DRQ_C3_CYCLES(40)) DUT (.clk_sys,
    .rst_n, .host_req, .host_rdata, .host_rdata_oe, .host_irq,
    .cfg_int_status, .soft_reset_active, .cmd_code, .cmd_start,
    .cmd_class, .drive_head, .busy, .drq, .status_misc,
    .write_in_progress, .card_is_drive1, .drive_active, .buffer_ready,
    .xfer_req, .transfer_done, .cmd_done, .irq_event);

  task automatic chk(input string nm, input logic [7:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_addr;
    @(posedge clk_sys) irq_event <= 1;
    @(posedge clk_sys) irq_event <= 0;
    #1 chk("irq", host_irq, 1);
    h.rd(4'h7, rd);
    chk("status", rd, 8'h75);
    chk("oe", host_rdata_oe, 8'hFF);
    chk("irq", host_irq, 0);
    h.rd(4'hF, rd);
    chk("oe", host_rdata_oe, 8'h7F);
    chk("daddr", rd & 8'h7F, 8'h7E);
    @(posedge clk_sys);
    write_in_progress <= 1;
    card_is_drive1 <= 1;
    h.wr(4'h6, 8'hB5);
    h.rd(4'hF, rd);
    chk("daddr", rd & 8'h7F, 8'h29);
    @(posedge clk_sys) drive_active <= 0;
    h.rd(4'hF, rd);
    chk("daddr", rd & 8'h7F, 8'h2B);
    @(posedge clk_sys);
    write_in_progress <= 0;
    card_is_drive1 <= 0;
    drive_active <= 1;
  endtask
  task automatic t_irq;
    h.wr(4'h7, 8'h20);
    chk("busy", busy, 1);
    chk("start", cmd_start, 1);
    @(posedge clk_sys) xfer_req <= 1;
    @(posedge clk_sys) xfer_req <= 0;
    #1 chk("drq", drq, 1);
    chk("busy", busy, 0);
    h.rd(4'h7, rd);
    chk("status", rd, 8'h7D);
    @(posedge clk_sys) transfer_done <= 1;
    @(posedge clk_sys) transfer_done <= 0;
    #1 chk("drq", drq, 0);
    chk("busy", busy, 1);
    @(posedge clk_sys) cmd_done <= 1;
    @(posedge clk_sys) cmd_done <= 0;
    #1 chk("irq", host_irq, 1);
    chk("cfg", cfg_int_status, 1);
    h.rd(4'hE, rd);
    chk("alt", rd, 8'h75);
    chk("irq", host_irq, 1);
    h.wr(4'hE, 8'hFB);
    chk("oe", host_rdata_oe, 8'h00);
    chk("irq", host_irq, 0);
    chk("cfg", cfg_int_status, 0);
    chk("srst", soft_reset_active, 0);
    h.wr(4'hE, 8'hF9);
    chk("irq", host_irq, 1);
    h.rd(4'h7, rd);
    chk("irq", host_irq, 0);
  endtask
  task automatic t_soft;
    h.wr(4'h6, 8'hAF);
    chk("dh", drive_head, 8'hAF);
    h.wr(4'hE, 8'h06);
    chk("srst", soft_reset_active, 1);
    chk("busy", busy, 1);
    repeat (3) @(posedge clk_sys);
    #1 chk("busy", busy, 1);
    chk("dh", drive_head, 8'hA0);
    h.wr(4'hE, 8'h00);
    chk("busy", busy, 0);
  endtask
  task automatic t_hwrst;
    h.wr(4'hE, 8'h02);
    @(posedge clk_sys) irq_event <= 1;
    @(posedge clk_sys) irq_event <= 0;
    #1 chk("irq", host_irq, 0);
    @(posedge clk_sys) rst_n <= 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys) irq_event <= 1;
    @(posedge clk_sys) irq_event <= 0;
    #1 chk("irq", host_irq, 1);
    chk("cfg", cfg_int_status, 1);
  endtask
  task automatic t_class(input logic [7:0] c, input int lim, input bit r);
    int n;
    h.wr(4'h7, c);
    chk("busy", busy, 1);
    chk("cls", cmd_class, lim == 20 ? 8'h1 : 8'h2);
    h.wr_raw(4'h7, 8'h20);
    chk("code", cmd_code, c);
    n = 3;
    if (r)
    begin
      @(posedge clk_sys) buffer_ready <= 1;
      @(posedge clk_sys) buffer_ready <= 0;
      #1 chk("drq", drq, 1);
    end
    while (drq !== 1'b1 && n < lim + 4)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("late", n <= lim + 1, 1);
    chk("busy", busy, 0);
    @(posedge clk_sys) transfer_done <= 1;
    @(posedge clk_sys) transfer_done <= 0;
    #1 chk("drq", drq, 0);
    @(posedge clk_sys) cmd_done <= 1;
    @(posedge clk_sys) cmd_done <= 0;
    #1 chk("busy", busy, 0);
  endtask

  initial
  begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    rst_n = 0;
    status_misc = 8'h7F;
    {write_in_progress, card_is_drive1, buffer_ready, xfer_req} = '0;
    {transfer_done, cmd_done, irq_event} = '0;
    drive_active = 1;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    t_addr();
    t_irq();
    t_soft();
    for (int i = 0; i < 10; i++)
      t_class(codes[i], i < 8 ? 20 : 40, i[0]);
    t_hwrst();
    results();
  end
endmodule // tb_top
`default_nettype wire
